// ===== core/atf_pkg.sv
// Summary of operation
// - a fan start forces full duty for the spin-up time, then normal control
// - spin-up time selection is ignored while spin-up is disabled
// - spin-up disable set suppresses spin-up; cleared enables it
// - floor duty register at 0x21, resets to 0x55, used at or below threshold
// - local mode: duty equals floor while local temp at or below its threshold
// - local threshold bits 7:3, 4 degrees per code, 0 to 124
// - local control register at 0x24, resets to 0x41
// - local slope bits 2:0, codes 0..4 give 32,16,8,4,2 LSB per degree
// - remote mode: duty equals floor while remote temp at or below threshold
// - remote control register at 0x25, resets to 0x61, threshold 4 degree steps
// - remote slope bits 2:0, codes 0..4 give 32,16,8,4,2 LSB per degree
// - remote slope sets duty rise per degree above remote threshold
package atf_pkg;
  // register indices, byte address is four times the index
  localparam logic [5:0] IDX_SPIN_CFG = 6'h20;
  localparam logic [5:0] IDX_FLOOR    = 6'h21;
  localparam logic [5:0] IDX_LOCAL    = 6'h24;
  localparam logic [5:0] IDX_REMOTE   = 6'h25;
  localparam logic [5:0] IDX_CTRL     = 6'h26;
  localparam logic [5:0] IDX_DUTY     = 6'h27;
  localparam logic [5:0] IDX_STATUS   = 6'h28;
  // reset values
  localparam logic [7:0] RST_SPIN_CFG = 8'h05;
  localparam logic [7:0] RST_FLOOR    = 8'h55;
  localparam logic [7:0] RST_LOCAL    = 8'h41;
  localparam logic [7:0] RST_REMOTE   = 8'h61;
  localparam logic [7:0] RST_CTRL     = 8'h00;
  // field positions
  localparam int SPIN_DIS_BIT   = 7;
  localparam int CTRL_REMOTE    = 0;
  localparam int CTRL_START     = 1;
  localparam int THR_LSB        = 3;
  localparam int THR_STEP_SHIFT = 2;
  localparam logic [2:0] SLOPE_MAX_CODE = 3'h4;
  localparam logic [2:0] SLOPE_TOP_SHIFT = 3'h5;
  // timing: spin-up counted in 100 ms ticks
  localparam int CLK_HZ       = 20_000_000;
  localparam int SPIN_TICK_MS = 100;
  localparam int TICK_CYCLES  = CLK_HZ / 1000 * SPIN_TICK_MS;
  // spin-up lengths in ticks: 0.2 0.4 0.6 0.8 1 2 4 8 seconds
  localparam logic [6:0] SPIN_TICKS [8] = '{7'h02, 7'h04, 7'h06, 7'h08,
                                            7'h0A, 7'h14, 7'h28, 7'h50};
  localparam logic [7:0] FULL_DUTY = 8'hFF;
endpackage : atf_pkg

// ===== core/atf_duty_core.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module atf_duty_core #(
  parameter int TICK_CYCLES = atf_pkg::TICK_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // measured temperatures, whole degrees, same clock domain
  input  wire logic [7:0]  local_temp,
  input  wire logic [7:0]  remote_temp,
  // fan duty output
  output logic [7:0]       pwm_duty,
  output logic             spinup_active
);
  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  logic [7:0]    spin_cfg;
  logic [7:0]    floor_duty_value;
  logic [7:0]    local_curve;
  logic [7:0]    remote_curve;
  logic          remote_sel;
  logic [TW-1:0] tick_cnt;
  logic [6:0]    spin_left;

  // bus decode
  wire        acc_done   = psel & penable & pready;
  wire        wr_en      = acc_done & pwrite;
  wire [5:0]  idx        = paddr[7:2];
  wire        hit_spin   = (idx == atf_pkg::IDX_SPIN_CFG);
  wire        hit_floor  = (idx == atf_pkg::IDX_FLOOR);
  wire        hit_local  = (idx == atf_pkg::IDX_LOCAL);
  wire        hit_remote = (idx == atf_pkg::IDX_REMOTE);
  wire        hit_ctrl   = (idx == atf_pkg::IDX_CTRL);
  wire        hit_duty   = (idx == atf_pkg::IDX_DUTY);
  wire        hit_stat   = (idx == atf_pkg::IDX_STATUS);
  wire        mapped     = hit_spin | hit_floor | hit_local | hit_remote |
                           hit_ctrl | hit_duty | hit_stat;
  wire        bad_addr   = !mapped || (paddr[1:0] != 2'h0);

  // read mux
  wire [7:0]  rd_byte = hit_spin   ? spin_cfg :
                        hit_floor  ? floor_duty_value :
                        hit_local  ? local_curve :
                        hit_remote ? remote_curve :
                        hit_ctrl   ? {7'h00, remote_sel} :
                        hit_duty   ? pwm_duty :
                        hit_stat   ? {7'h00, spinup_active} : 8'h00;

  // spin-up configuration fields
  wire        spinup_disable      = spin_cfg[atf_pkg::SPIN_DIS_BIT];
  wire [2:0]  spinup_duration_sel = spin_cfg[2:0];
  wire        start_req = wr_en && hit_ctrl && pwdata[atf_pkg::CTRL_START];
  wire        tick      = (tick_cnt == TW'(TICK_CYCLES - 1));

  // pick the active sensor curve
  wire [7:0]  temp       = remote_sel ? remote_temp : local_temp;
  wire [7:0]  curve      = remote_sel ? remote_curve : local_curve;
  wire [4:0]  thr_code   = curve[7:atf_pkg::THR_LSB];
  wire [7:0]  thr_deg    = {1'b0, thr_code, 2'h0};
  wire [2:0]  slope_raw  = curve[2:0];
  wire [2:0]  slope_code = (slope_raw > atf_pkg::SLOPE_MAX_CODE) ?
                           atf_pkg::SLOPE_MAX_CODE : slope_raw;
  wire        above      = (temp > thr_deg);
  wire [7:0]  excess     = above ? 8'(temp - thr_deg) : 8'h00;
  wire [2:0]  shamt      = 3'(atf_pkg::SLOPE_TOP_SHIFT - slope_code);
  wire [13:0] rise       = 14'({6'h00, excess} << shamt);
  wire [13:0] sum        = 14'(rise + {6'h00, floor_duty_value});
  wire [7:0]  auto_duty  = !above ? floor_duty_value :
                           (sum > 14'h00FF) ? atf_pkg::FULL_DUTY : sum[7:0];
  wire [7:0]  next_duty  = spinup_active ? atf_pkg::FULL_DUTY : auto_duty;

  // apb handshake: one wait state, read data and error registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & penable & ~pready;
      if (psel & penable & ~pready) begin
        prdata  <= (pwrite || bad_addr) ? 32'h0000_0000 : {24'h00_0000, rd_byte};
        pslverr <= bad_addr;
      end
    end
  end

  // writable registers, read-only indices ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_cfg         <= atf_pkg::RST_SPIN_CFG;
      floor_duty_value <= atf_pkg::RST_FLOOR;
      local_curve      <= atf_pkg::RST_LOCAL;
      remote_curve     <= atf_pkg::RST_REMOTE;
      remote_sel       <= atf_pkg::RST_CTRL[atf_pkg::CTRL_REMOTE];
    end else if (wr_en && !bad_addr) begin
      if (hit_spin)   spin_cfg         <= {pwdata[7], 4'h0, pwdata[2:0]};
      if (hit_floor)  floor_duty_value <= pwdata[7:0];
      if (hit_local)  local_curve      <= pwdata[7:0];
      if (hit_remote) remote_curve     <= pwdata[7:0];
      if (hit_ctrl)   remote_sel       <= pwdata[atf_pkg::CTRL_REMOTE];
    end
  end

  // tick divider runs only while spinning up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else if (start_req || !spinup_active || tick) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
    end
  end

  // spin-up sequencer: full duty until the selected time has run out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spin_left     <= 7'h00;
      spinup_active <= 1'b0;
    end else if (start_req && !spinup_disable) begin
      spin_left     <= atf_pkg::SPIN_TICKS[spinup_duration_sel];
      spinup_active <= 1'b1;
    end else if (spinup_disable) begin
      spin_left     <= 7'h00;
      spinup_active <= 1'b0;
    end else if (spinup_active && tick) begin
      spin_left     <= 7'(spin_left - 1'b1);
      spinup_active <= (spin_left != 7'h01);
    end
  end

  // duty output register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_duty <= atf_pkg::RST_FLOOR;
    end else begin
      pwm_duty <= next_duty;
    end
  end
endmodule : atf_duty_core

// ===== verif/atf_duty_core_assertions.sv
`timescale 1ns/100ps
module atf_duty_core_assertions (
  // apb side and fan side of the core
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [7:0]  paddr, pwm_duty,
  input wire logic [31:0] pwdata, prdata,
  input wire logic        spinup_active
);
  logic dis;
  wire  cmt = psel & penable & pready & pwrite;
  // shadow of the spin-up disable bit
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) dis <= 1'b0;
    else if (cmt && paddr == 8'h80) dis <= pwdata[7];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_wait; psel && $rose(penable) |-> !pready ##1 pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not in second access cycle");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_full; spinup_active && $past(spinup_active) |-> pwm_duty == 8'hFF; endproperty
  a_full: assert property (p_full) else $error("duty not full in spin-up");
  property p_start; cmt && paddr == 8'h98 && pwdata[1] && !dis |=> spinup_active; endproperty
  a_start: assert property (p_start) else $error("start did not spin up");
  property p_dis; dis && $past(dis) |-> !spinup_active; endproperty
  a_dis: assert property (p_dis) else $error("spin-up while disabled");
  property p_err; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("misaligned access not refused");
  property p_rd0; pready && !pwrite && pslverr |-> prdata == 32'h0; endproperty
  a_rd0: assert property (p_rd0) else $error("refused read not zero");
  property p_map; pready && paddr inside {8'h80, 8'h84, 8'h90, 8'h94, 8'h98} |-> !pslverr;
  endproperty
  a_map: assert property (p_map) else $error("mapped register refused");
  c_spin: cover property ($rose(spinup_active));
  c_err: cover property (pready && pslverr);
  c_dis: cover property (dis && cmt && paddr == 8'h98 && pwdata[1]);
endmodule : atf_duty_core_assertions
bind atf_duty_core atf_duty_core_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .pready, .pslverr, .paddr, .pwm_duty, .pwdata, .prdata, .spinup_active);

// ===== verif/atf_fan_model.sv
`timescale 1ns/100ps
module atf_fan_model (
  input wire logic       pclk,
  input wire logic [7:0] pwm_duty,
  output logic     [7:0] fan_speed
);
  // fan speed follows the drive level one edge late
  always_ff @(posedge pclk) fan_speed <= pwm_duty;
endmodule : atf_fan_model

// ===== verif/tb_auto_temp_fan_duty_params.sv
`timescale 1ns/100ps
module tb_auto_temp_fan_duty_params;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, sr;
  logic [7:0]  paddr = 0, local_temp = 0, remote_temp = 0, pwm_duty, fan_speed, fl, lc, rc, t1, t2;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        spinup_active;
  int          fail_count = 0, n_tests = 0, n;
  always #25 pclk = ~pclk;
  atf_duty_core #(.TICK_CYCLES(4)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .local_temp, .remote_temp, .pwm_duty, .spinup_active);
  atf_fan_model fan_u (.pclk, .pwm_duty, .fan_speed);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // expected duty from floor, curve register and temperature
  function automatic logic [7:0] ed(logic [7:0] f, logic [7:0] c, logic [7:0] t);
    int s = 32 >> ((c[2:0] > 3'h4) ? 4 : c[2:0]);
    int d = (t <= c[7:3] * 4) ? f : f + (t - c[7:3] * 4) * s;
    return (d > 255) ? 8'hFF : d[7:0];
  endfunction : ed
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(32'hECDD));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h84, 0); chk(rd, atf_pkg::RST_FLOOR);
    apb(0, 8'h90, 0); chk(rd, atf_pkg::RST_LOCAL);
    apb(0, 8'h94, 0); chk(rd, atf_pkg::RST_REMOTE);
    apb(0, 8'h80, 0); chk(rd, atf_pkg::RST_SPIN_CFG);
    apb(0, 8'h86, 0); chk(er, 1'b1);
    apb(1, 8'h04, 32'hFF); chk(er, 1'b1);
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      {fl, lc, rc, t1, t2, sr} = {$urandom, $urandom};
      if (i % 4 == 0) {t1, t2} = {1'b0, lc[7:3], 2'h0, 1'b0, rc[7:3], 2'h0};
      apb(1, 8'h84, fl);
      apb(1, 8'h90, lc);
      apb(1, 8'h94, rc);
      apb(1, 8'h98, sr);
      {local_temp, remote_temp} <= {t1, t2};
      repeat (3) @(posedge pclk);
      chk(pwm_duty, sr ? ed(fl, rc, t2) : ed(fl, lc, t1));
    end
    $display("test curves done");
    for (int s = 0; s < 8; s++) begin
      apb(1, 8'h80, s);
      apb(1, 8'h98, 32'h2);
      n = 0;
      for (int c = 0; c < 400; c++) begin
        @(posedge pclk);
        n += (spinup_active === 1'b1);
        if (c == 6) chk(fan_speed, 8'hFF);
      end
      chk(n, atf_pkg::SPIN_TICKS[s] * 4);
    end
    $display("test spin-up done");
    apb(1, 8'h80, 32'h87);
    apb(1, 8'h98, 32'h2);
    repeat (3) @(posedge pclk);
    chk(spinup_active, 1'b0);
    apb(1, 8'h80, 32'h07);
    apb(1, 8'h98, 32'h2);
    apb(1, 8'h80, 32'h80);
    repeat (2) @(posedge pclk);
    chk(spinup_active, 1'b0);
    $display("test disable done");
    end_of_test();
  end
endmodule : tb_auto_temp_fan_duty_params
